// [bench/serial_core_model.sv]
/*
 * Behavioural model of the serial core that faces the register bank.
 * Assumes the bench calls its tasks one at a time, from one process.
 */
`timescale 1ns/10ps
module serial_core_model
(
    input  wire logic  clk,
    output logic       rx_valid,
    output logic [7:0] rx_byte,
    output logic       fe,
    output logic       pe,
    output logic       take,
    output logic       done,
    output logic       rx_busy,
    output logic       tx_busy
);
    // ------------------------------------------------------------------
    // Idle levels
    // ------------------------------------------------------------------
    initial
    begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
        fe       = 1'b0;
        pe       = 1'b0;
        take     = 1'b0;
        done     = 1'b0;
        rx_busy  = 1'b0;
        tx_busy  = 1'b0;
    end

    // One received byte; qualifiers go to the inverse after the pulse
    // so a bank that ignores the pulse qualifier gets wrong data
    task automatic rx(input logic [7:0] b, input logic f, input logic p);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        fe       <= f;
        pe       <= p;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_byte  <= ~b;
        fe       <= ~f;
        pe       <= ~p;
    endtask

    // One-cycle transmit event: take (0) or done (1)
    task automatic tx(input logic is_done);
        @(posedge clk);
        take <= ~is_done;
        done <= is_done;
        @(posedge clk);
        take <= 1'b0;
        done <= 1'b0;
    endtask

    // Busy levels stand until changed
    task automatic busy(input logic r, input logic t);
        @(posedge clk);
        rx_busy <= r;
        tx_busy <= t;
    endtask
endmodule // serial_core_model

// [bench/uart_register_interface_bench.sv]
/*
 * Self-checking bench of the serial register bank against a queue model.
 * Assumes the core model drives the core side and the bench the bus.
 */
`timescale 1ns/10ps
`include "uart_regs_defines.svh"
module uart_register_interface_bench;
    logic                 sys_clk, rst, clk_en, wr, rd;
    logic [15:0]          addr, wdata;
    uart_regs_pkg::word_t rdata, clock_cfg, mode_cfg, baud_cfg, d;
    uart_regs_pkg::byte_t tx_byte;
    logic                 module_en, soft_reset, tx_buf_empty, irq;
    logic                 rx_valid, rfe, rpe, take, done, rbsy, tbsy;
    logic [7:0]           rx_byte;
    logic [7:0]           tx_exp;
    int                   num_errors = 0, n_compared = 0;
    int                   fl = 1, en = 0, rb = 0, tb = 0, i;
    logic [7:0]           q[$];
    logic [15:0]          offs[4], msk[4], cfg[4];

    // ------------------------------------------------------------------
    // Clock, instances
    // ------------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    uart_register_interface uart_register_interface_i (.SYS_CLK(sys_clk), .RST(rst),
        .CLK_EN(clk_en), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .RX_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_FRAMING_ERR(rfe), .RX_PARITY_ERR(rpe),
        .TX_TAKE(take), .TX_DONE(done), .RX_BUSY(rbsy), .TX_BUSY(tbsy),
        .CLOCK_CFG(clock_cfg), .MODE_CFG(mode_cfg), .BAUD_CFG(baud_cfg),
        .MODULE_EN(module_en), .SOFT_RESET(soft_reset), .TX_BYTE(tx_byte),
        .TX_BUF_EMPTY(tx_buf_empty), .IRQ(irq));

    serial_core_model serial_core_model_i (.clk(sys_clk), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .fe(rfe), .pe(rpe), .take(take), .done(done),
        .rx_busy(rbsy), .tx_busy(tbsy));

    // ------------------------------------------------------------------
    // Compare, bus and model tasks
    // ------------------------------------------------------------------
    task automatic chk_word(input uart_regs_pkg::word_t got, input uart_regs_pkg::word_t exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [15:0] a, output uart_regs_pkg::word_t v);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    function automatic uart_regs_pkg::word_t stat();
        return 16'(fl | (q.size() > 0 ? 2 : 0) | (q.size() > 1 ? 4 : 0) | (rb << 9) | (tb << 8));
    endfunction

    task automatic chk_stat();
        uart_regs_pkg::word_t s;
        rd_reg(`OFF_STATUS, s);
        chk_word(s, stat());
        chk_bit(irq, |(stat() & en));
    endtask

    task automatic ev_rx(input logic [7:0] b, input logic f, input logic p);
        serial_core_model_i.rx(b, f, p);
        if (q.size() == 2)
            fl |= 8;
        else
        begin
            q.push_back(b);
            fl |= (f ? 32 : 0) | (p ? 16 : 0);
        end
        chk_stat();
    endtask

    // Data read pops the oldest byte and clears both error flags
    task automatic rd_rx();
        uart_regs_pkg::word_t v;
        rd_reg(`OFF_RX_DATA, v);
        chk_word(v, {8'h00, q.pop_front()});
        fl &= ~32'h30;
        chk_stat();
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Hang guard: a run this long counts as a mismatch
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        clk_en = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 16'h0000;
        wdata = 16'h0000;
        offs = '{`OFF_CLOCK_CTRL, `OFF_MODE, `OFF_BAUD_RATE, `OFF_IRQ_EN};
        msk = '{`MASK_CLOCK_CTRL, `MASK_MODE, `MASK_BAUD_RATE, {9'h000, `MASK_IRQ_EN}};
        void'($urandom(32'h0c49));
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;

        // Reset values of the config, transmit and status registers and of the empty and IRQ pins
        for (i = 0; i < 4; i++)
        begin
            rd_reg(offs[i], d);
            chk_word(d, 16'h0000);
        end
        rd_reg(`OFF_TX_DATA, d);
        chk_word(d, 16'h0000);
        chk_bit(tx_buf_empty, 1'b1);
        chk_stat();
        $display("test reset done");

        // Random config words; reserved bits read zero
        for (i = 0; i < 4; i++)
        begin
            cfg[i] = 16'($urandom) & msk[i];
            wr_reg(offs[i], cfg[i] | ~msk[i]);
            rd_reg(offs[i], d);
            chk_word(d, cfg[i]);
        end
        en = cfg[3];
        chk_word(clock_cfg, cfg[0]);
        chk_word(mode_cfg, cfg[1]);
        chk_word(baud_cfg, cfg[2]);
        wr_reg(16'h4390, 16'hffff);
        rd_reg(16'h4390, d);
        chk_word(d, 16'h0000);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr_reg(`OFF_BAUD_RATE, ~cfg[2]);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd_reg(`OFF_BAUD_RATE, d);
        chk_word(d, cfg[2]);
        $display("test config done");

        // Transmit data write clears empty, core take sets it again
        for (i = 0; i < 3; i++)
        begin
            d = 16'($urandom);
            tx_exp = d[7:0];
            wr_reg(`OFF_TX_DATA, d);
            fl &= ~1;
            // Let the write edge settle before looking at the registered outputs
            #1;
            chk_word({8'h00, tx_byte}, {8'h00, tx_exp});
            chk_bit(tx_buf_empty, 1'b0);
            rd_reg(`OFF_TX_DATA, d);
            chk_word(d, {8'h00, tx_exp});
            chk_stat();
            serial_core_model_i.tx(1'b0);
            fl |= 1;
            #1;
            chk_bit(tx_buf_empty, 1'b1);
            chk_stat();
        end
        $display("test transmit done");

        // Fill store, overrun, read-only flag bits, pop
        serial_core_model_i.busy(1'b1, 1'b1);
        rb = 1;
        tb = 1;
        wr_reg(`OFF_IRQ_EN, 16'h007f);
        en = 16'h007f;
        ev_rx(8'($urandom), 1'b1, 1'b0);
        ev_rx(8'($urandom), 1'b0, 1'b1);
        ev_rx(8'($urandom), 1'b1, 1'b1);
        wr_reg(`OFF_STATUS, 16'h0307);
        chk_stat();
        rd_rx();
        rd_rx();
        $display("test receive done");

        // Write-one clear; write-zero keeps
        serial_core_model_i.tx(1'b1);
        fl |= 64;
        wr_reg(`OFF_STATUS, 16'h0000);
        chk_stat();
        wr_reg(`OFF_STATUS, 16'h0040);
        fl &= ~64;
        chk_stat();
        wr_reg(`OFF_STATUS, 16'h0008);
        fl &= ~8;
        chk_stat();
        ev_rx(8'($urandom), 1'b1, 1'b1);
        wr_reg(`OFF_STATUS, 16'h0030);
        fl &= ~32'h30;
        chk_stat();
        $display("test clear done");

        // Soft reset flushes store and flags
        serial_core_model_i.busy(1'b0, 1'b0);
        serial_core_model_i.tx(1'b1);
        wr_reg(`OFF_CONTROL, 16'h0003);
        #1;
        chk_bit(soft_reset, 1'b1);
        chk_bit(module_en, 1'b1);
        fl = 1;
        rb = 0;
        tb = 0;
        q.delete();
        rd_reg(`OFF_CONTROL, d);
        chk_word(d, 16'h0001);
        chk_stat();
        en = 16'($urandom) & 16'h007f;
        wr_reg(`OFF_IRQ_EN, en[15:0]);
        ev_rx(8'($urandom), 1'b1, 1'b0);
        $display("test soft reset done");
        finish_test();
    end
endmodule // uart_register_interface_bench

// [rtl/rx_store.sv]
/*
 * Two-entry receive store; the oldest byte always sits in a register.
 * Assumes the controller never pushes into a full store without a pop.
 */
`timescale 1ns/10ps
`include "uart_regs_defines.svh"
module rx_store
(
    input  wire logic  clk,
    input  wire logic  rst,
    rx_store_if.store  st
);
    uart_regs_pkg::byte_t tail;
    logic                 push_eff;
    logic                 pop_eff;

    // ------------------------------------------------------------------------
    // Effective operations
    // ------------------------------------------------------------------------
    // A push into a full store is dropped unless a pop frees a slot
    assign pop_eff  = st.pop & (st.count != 2'h0);
    assign push_eff = st.push & ((st.count != `RX_STORE_FULL) | pop_eff);

    // Occupancy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st.count <= 2'h0;
        else if (st.ce)
        begin
            if (st.flush)
                st.count <= 2'h0;
            else if (push_eff & ~pop_eff)
                st.count <= st.count + 2'h1;
            else if (pop_eff & ~push_eff)
                st.count <= st.count - 2'h1;
        end
    end

    // Head and tail entries
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st.head <= `RST_BYTE;
            tail    <= `RST_BYTE;
        end
        else if (st.ce & ~st.flush)
        begin
            if (push_eff & ((st.count == 2'h0) | ((st.count == 2'h1) & pop_eff)))
                st.head <= st.push_data;
            else if (pop_eff & (st.count == `RX_STORE_FULL))
                st.head <= tail;
            if (push_eff & (((st.count == 2'h1) & ~pop_eff) | (st.count == `RX_STORE_FULL)))
                tail <= st.push_data;
        end
    end
endmodule // rx_store

// [rtl/rx_store_if.sv]
/*
 * Carrier between the register bank and its two-entry receive store.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
interface rx_store_if;
    logic                  ce;
    logic                  flush;
    logic                  push;
    uart_regs_pkg::byte_t  push_data;
    logic                  pop;
    uart_regs_pkg::byte_t  head;
    uart_regs_pkg::level_t count;

    modport store (input ce, input flush, input push, input push_data, input pop,
                   output head, output count);
    modport ctrl  (output ce, output flush, output push, output push_data, output pop,
                   input head, input count);
endinterface

// [rtl/uart_register_interface.sv]
/*
 * Register bank of one asynchronous serial channel: clock, mode, baud, control,
 * transmit and receive data, status flags and interrupt enables.
 * Assumes a serial core outside that reports received bytes, errors and
 * transmit events as one-cycle pulses synchronous to SYS_CLK.
 */
`timescale 1ns/10ps
// Offsets, masks and flag positions shared with the store and the bench
`include "uart_regs_defines.svh"
module uart_register_interface
(
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire logic                  CLK_EN,
    input  wire logic [15:0]           ADDR,
    input  wire logic [15:0]           WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output uart_regs_pkg::word_t       RDATA,
    input  wire logic                  RX_VALID,
    input  wire logic [7:0]            RX_BYTE,
    input  wire logic                  RX_FRAMING_ERR,
    input  wire logic                  RX_PARITY_ERR,
    input  wire logic                  TX_TAKE,
    input  wire logic                  TX_DONE,
    input  wire logic                  RX_BUSY,
    input  wire logic                  TX_BUSY,
    output uart_regs_pkg::word_t       CLOCK_CFG,
    output uart_regs_pkg::word_t       MODE_CFG,
    output uart_regs_pkg::word_t       BAUD_CFG,
    output logic                       MODULE_EN,
    output logic                       SOFT_RESET,
    output uart_regs_pkg::byte_t       TX_BYTE,
    output logic                       TX_BUF_EMPTY,
    output logic                       IRQ
);
    // ------------------------------------------------------------------------
    // Decode and events
    // ------------------------------------------------------------------------
    rx_store_if            st ();
    uart_regs_pkg::flags_t flags;
    uart_regs_pkg::flags_t irq_en;
    uart_regs_pkg::flags_t set_vec;
    uart_regs_pkg::flags_t clr_vec;
    logic                  wr_status;
    logic                  wr_tx;
    logic                  rd_rx;
    logic                  soft_now;
    logic                  push_ok;
    logic                  pop_ok;
    logic                  rx_busy;
    logic                  tx_busy;

    assign wr_status = WR & (ADDR == `OFF_STATUS);
    assign wr_tx     = WR & (ADDR == `OFF_TX_DATA);
    assign rd_rx     = RD & (ADDR == `OFF_RX_DATA);
    assign soft_now  = WR & (ADDR == `OFF_CONTROL) & WDATA[`BIT_SOFT_RESET];
    assign pop_ok    = rd_rx & (st.count != 2'h0);
    // A byte finds room if the store is not full or a read frees a slot
    assign push_ok   = RX_VALID & ((st.count != `RX_STORE_FULL) | pop_ok);

    // Store hookup; bus and core strobes only act while the clock enable is high
    assign st.ce        = CLK_EN;
    assign st.flush     = soft_now;
    assign st.push      = push_ok;
    assign st.push_data = RX_BYTE;
    assign st.pop       = rd_rx;

    rx_store u_rx_store
    (
        .clk (SYS_CLK),
        .rst (RST),
        .st  (st.store)
    );

    // ------------------------------------------------------------------------
    // Flag set and clear terms
    // ------------------------------------------------------------------------
    // Set terms from the core and the store; sets override clears below
    always_comb
    begin
        set_vec = 7'h00;
        set_vec[`FLAG_TX_COMPLETE] = TX_DONE;
        set_vec[`FLAG_FRAMING]     = push_ok & RX_FRAMING_ERR;
        set_vec[`FLAG_PARITY]      = push_ok & RX_PARITY_ERR;
        set_vec[`FLAG_OVERRUN]     = RX_VALID & ~push_ok;
        set_vec[`FLAG_RX_TWO]      = push_ok & (((st.count == 2'h1) & ~pop_ok) |
                                                (st.count == `RX_STORE_FULL));
        set_vec[`FLAG_RX_ONE]      = push_ok;
        set_vec[`FLAG_TX_EMPTY]    = TX_TAKE;
    end

    // Clear terms from software
    always_comb
    begin
        clr_vec = 7'h00;
        clr_vec[`FLAG_TX_COMPLETE] = wr_status & WDATA[`FLAG_TX_COMPLETE];
        clr_vec[`FLAG_OVERRUN]     = wr_status & WDATA[`FLAG_OVERRUN];
        clr_vec[`FLAG_FRAMING]     = (wr_status & WDATA[`FLAG_FRAMING]) | rd_rx;
        clr_vec[`FLAG_PARITY]      = (wr_status & WDATA[`FLAG_PARITY]) | rd_rx;
        // Buffer-full flags ignore writes; a read drops one level
        clr_vec[`FLAG_RX_TWO]      = pop_ok;
        clr_vec[`FLAG_RX_ONE]      = pop_ok & (st.count == 2'h1);
        clr_vec[`FLAG_TX_EMPTY]    = wr_tx;
    end

    // ------------------------------------------------------------------------
    // Status flags, one flop per bit
    // ------------------------------------------------------------------------
    // Soft reset restores flag reset values, the empty flag coming back as one
    genvar gi;
    generate
        for (gi = 0; gi < `FLAG_COUNT; gi++)
        begin : g_flag
            localparam uart_regs_pkg::flags_t RST_V = `RST_FLAGS;
            always_ff @(posedge SYS_CLK or posedge RST)
            begin
                if (RST)
                    flags[gi] <= RST_V[gi];
                else if (CLK_EN)
                begin
                    if (soft_now)
                        flags[gi] <= RST_V[gi];
                    else
                        flags[gi] <= set_vec[gi] | (flags[gi] & ~clr_vec[gi]);
                end
            end
        end
    endgenerate

    // Busy levels from the core, cleared by soft reset
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            rx_busy <= 1'b0;
            tx_busy <= 1'b0;
        end
        else if (CLK_EN)
        begin
            rx_busy <= RX_BUSY & ~soft_now;
            tx_busy <= TX_BUSY & ~soft_now;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    // Reserved bits are masked off on write so outputs and reads stay clean
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
        begin
            CLOCK_CFG <= `RST_WORD;
            MODE_CFG  <= `RST_WORD;
            BAUD_CFG  <= `RST_WORD;
            MODULE_EN <= 1'b0;
            irq_en    <= 7'h00;
        end
        else if (CLK_EN & WR)
        begin
            case (ADDR)
                `OFF_CLOCK_CTRL: CLOCK_CFG <= WDATA & `MASK_CLOCK_CTRL;
                `OFF_MODE:       MODE_CFG  <= WDATA & `MASK_MODE;
                `OFF_BAUD_RATE:  BAUD_CFG  <= WDATA & `MASK_BAUD_RATE;
                `OFF_CONTROL:    MODULE_EN <= WDATA[`BIT_MODULE_EN];
                `OFF_IRQ_EN:     irq_en    <= WDATA[6:0] & `MASK_IRQ_EN;
                default:         irq_en    <= irq_en;
            endcase
        end
    end

    // Soft reset pulse to the core; the bit itself reads back as zero
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            SOFT_RESET <= 1'b0;
        else if (CLK_EN)
            SOFT_RESET <= soft_now;
    end

    // ------------------------------------------------------------------------
    // Transmit data
    // ------------------------------------------------------------------------
    // Only the low byte is held; software may overwrite before the core takes it
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            TX_BYTE <= `RST_BYTE;
        else if (CLK_EN & wr_tx)
            TX_BYTE <= WDATA[7:0];
    end

    // Empty flag mirrored to the core from its own flop copy
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            TX_BUF_EMPTY <= 1'b1;
        else if (CLK_EN)
        begin
            if (soft_now)
                TX_BUF_EMPTY <= 1'b1;
            else
                TX_BUF_EMPTY <= TX_TAKE | (TX_BUF_EMPTY & ~wr_tx);
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt request and read port
    // ------------------------------------------------------------------------
    // Registered, so the request trails the flag by one cycle
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            IRQ <= 1'b0;
        else if (CLK_EN)
            IRQ <= |(flags & irq_en);
    end

    // Read data stand for one cycle while CLK_EN is high and hold while it is low; unmapped offsets read zero
    always_ff @(posedge SYS_CLK or posedge RST)
    begin
        if (RST)
            RDATA <= `RST_WORD;
        else if (CLK_EN)
        begin
            RDATA <= `RST_WORD;
            if (RD)
            begin
                case (ADDR)
                    `OFF_CLOCK_CTRL: RDATA <= CLOCK_CFG;
                    `OFF_MODE:       RDATA <= MODE_CFG;
                    `OFF_BAUD_RATE:  RDATA <= BAUD_CFG;
                    `OFF_CONTROL:    RDATA <= {15'h0000, MODULE_EN};
                    `OFF_TX_DATA:    RDATA <= {8'h00, TX_BYTE};
                    `OFF_RX_DATA:    RDATA <= {8'h00, st.head};
                    `OFF_STATUS:     RDATA <= {6'h00, rx_busy, tx_busy, 1'b0, flags};
                    `OFF_IRQ_EN:     RDATA <= {9'h000, irq_en};
                    default:         RDATA <= `RST_WORD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_status_w1(int b);
        CLK_EN && wr_status && WDATA[b];
    endsequence

    sequence s_rx_read;
        CLK_EN && rd_rx && !soft_now;
    endsequence

    a_w1c_tx_complete: assert property (@(posedge SYS_CLK) disable iff (RST)
        s_status_w1(`FLAG_TX_COMPLETE) ##0 !TX_DONE |=> !flags[`FLAG_TX_COMPLETE])
        else $error("tx complete flag not cleared by write one");

    a_w0_keeps_overrun: assert property (@(posedge SYS_CLK) disable iff (RST)
        CLK_EN && wr_status && !WDATA[`FLAG_OVERRUN] && !soft_now && flags[`FLAG_OVERRUN]
        |=> flags[`FLAG_OVERRUN])
        else $error("overrun flag lost on write zero");

    a_rx_read_errors: assert property (@(posedge SYS_CLK) disable iff (RST)
        s_rx_read ##0 !push_ok |=> !flags[`FLAG_FRAMING] && !flags[`FLAG_PARITY])
        else $error("error flags not cleared by receive read");

    a_error_set_wins: assert property (@(posedge SYS_CLK) disable iff (RST)
        s_status_w1(`FLAG_FRAMING) ##0 (push_ok && RX_FRAMING_ERR && !soft_now)
        |=> flags[`FLAG_FRAMING])
        else $error("framing event lost against clear");

    a_rx_flags_ro: assert property (@(posedge SYS_CLK) disable iff (RST)
        CLK_EN && wr_status && !RX_VALID && !RD
        |=> $stable(flags[`FLAG_RX_TWO:`FLAG_RX_ONE]))
        else $error("buffer flags changed by a write");

    a_rx_read_drains: assert property (@(posedge SYS_CLK) disable iff (RST)
        s_rx_read ##0 (!RX_VALID && st.count == 2'h1) |=> flags[2:1] == 2'h0)
        else $error("buffer flags not cleared by last read");

    a_tx_write_clears: assert property (@(posedge SYS_CLK) disable iff (RST)
        CLK_EN && wr_tx && !TX_TAKE && !soft_now
        |=> !flags[`FLAG_TX_EMPTY] && TX_BYTE == $past(WDATA[7:0]))
        else $error("transmit write did not load byte and clear empty");

    a_txd_upper_zero: assert property (@(posedge SYS_CLK) disable iff (RST)
        CLK_EN && RD && ADDR == `OFF_TX_DATA |=> RDATA[15:8] == 8'h00 && RDATA[7:0] == TX_BYTE)
        else $error("transmit data read back wrong");

    a_irq_tracks: assert property (@(posedge SYS_CLK) disable iff (RST)
        CLK_EN |=> IRQ == |($past(flags) & $past(irq_en)))
        else $error("interrupt request does not follow enabled flags");
endmodule // uart_register_interface

// [rtl/uart_regs_defines.svh]
/*
 * Register offsets, field positions, masks and reset values of the serial channel
 * register bank.
 * Assumes a 16-bit register port with byte addresses as printed.
 */
`ifndef UART_REGS_DEFINES_SVH
`define UART_REGS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFF_CLOCK_CTRL   16'h4380
`define OFF_MODE         16'h4382
`define OFF_BAUD_RATE    16'h4384
`define OFF_CONTROL      16'h4386
`define OFF_TX_DATA      16'h4388
`define OFF_RX_DATA      16'h438a
`define OFF_STATUS       16'h438c
`define OFF_IRQ_EN       16'h438e

// ----------------------------------------------------------------------------
// Writable masks (reserved bits read as zero)
// ----------------------------------------------------------------------------
`define MASK_CLOCK_CTRL  16'h0133
`define MASK_MODE        16'h037f
`define MASK_BAUD_RATE   16'h0fff
`define MASK_IRQ_EN      7'h7f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_SOFT_RESET   1
`define BIT_MODULE_EN    0
`define BIT_RX_BUSY      9
`define BIT_TX_BUSY      8
`define FLAG_TX_COMPLETE 6
`define FLAG_FRAMING     5
`define FLAG_PARITY      4
`define FLAG_OVERRUN     3
`define FLAG_RX_TWO      2
`define FLAG_RX_ONE      1
`define FLAG_TX_EMPTY    0
`define FLAG_COUNT       7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_WORD         16'h0000
`define RST_BYTE         8'h00
`define RST_FLAGS        7'h01
`define RX_STORE_FULL    2'h2

`endif

// [rtl/uart_regs_pkg.sv]
/*
 * Shared types of the serial channel register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package uart_regs_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0]  byte_t;
    typedef logic [1:0]  level_t;
    typedef logic [6:0]  flags_t;
endpackage
